// file: strap_cfg_map.svh
`ifndef STRAP_CFG_MAP_SVH
`define STRAP_CFG_MAP_SVH

// register byte address
`define CFG_ADDR 32'h0010_1000

// field layout of the configuration word
`define CFG_W 10
`define SEL_BIT 11
`define BIT_AGP 9
`define BIT_TV_HI 8
`define BIT_TV_LO 7
`define BIT_XTAL 6
`define BIT_HOST 5
`define BIT_WIDTH 4
`define BIT_PM 3
`define BIT_RAM 2
`define BIT_SUBV 1
`define BIT_SPEED 0

// byte lanes of the register
`define LANE0_HI 7
`define LANE1_LO 8

// reset values
`define CFG_RST 10'h000
`define SEL_RST 1'b0
`define WORD_ZERO 32'h0000_0000

// subsystem id preset and rom window
`define SUBSYS_ZERO 16'h0000
`define SUBSYS_ROM_FIRST 8'h54
`define SUBSYS_ROM_LAST 8'h57

// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: strap_cfg_pkg.sv
`include "strap_cfg_map.svh"

package strap_cfg_pkg;
   typedef logic [`CFG_W-1:0] cfg_t;
   typedef logic [1:0] resp_t;
   typedef enum logic [1:0]
   {
      TV_RESERVED = 2'b00,
      TV_NTSC = 2'b01,
      TV_PAL = 2'b10,
      TV_OFF = 2'b11
   } tv_format_e;
endpackage

// file: strap_cfg_if.sv
`timescale 1ns/1ps
interface strap_cfg_if;
   import strap_cfg_pkg::*;
   cfg_t effCfg;
   logic agpOneX;
   tv_format_e tvFormat;
   logic tvEnabled;
   logic refClk14m;
   logic hostIsAgp;
   logic fbWide128;
   logic pmRegsPresent;
   logic [7:0] chipIdentity;
   logic memType8Mbit;
   logic subsysFromRom;
   logic [15:0] subsysIdPreset;
   logic [7:0] subsysRomFirst;
   logic [7:0] subsysRomLast;
   logic bus66Capable;
   modport src (output effCfg, input agpOneX, tvFormat, tvEnabled, refClk14m, hostIsAgp,
      fbWide128, pmRegsPresent, chipIdentity, memType8Mbit, subsysFromRom, subsysIdPreset,
      subsysRomFirst, subsysRomLast, bus66Capable);
   modport dec (input effCfg, output agpOneX, tvFormat, tvEnabled, refClk14m, hostIsAgp,
      fbWide128, pmRegsPresent, chipIdentity, memType8Mbit, subsysFromRom, subsysIdPreset,
      subsysRomFirst, subsysRomLast, bus66Capable);
endinterface

// file: strap_field_decode.sv
`timescale 1ns/1ps
`include "strap_cfg_map.svh"

module strap_field_decode
   import strap_cfg_pkg::*;
#(
   parameter logic [7:0] ID_LEGACY = 8'h5A,
   parameter logic [7:0] ID_PM = 8'h5B
)
(
   input wire logic ref_clk,
   input wire logic reset_n,
   strap_cfg_if.dec cfg
);
   if (ID_LEGACY == ID_PM)
   begin : idClash
      $error("identity values must differ");
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cfg.agpOneX <= 1'b0;
         cfg.tvFormat <= TV_RESERVED;
         cfg.tvEnabled <= 1'b0;
         cfg.refClk14m <= 1'b0;
         cfg.hostIsAgp <= 1'b0;
         cfg.fbWide128 <= 1'b0;
         cfg.pmRegsPresent <= 1'b0;
         cfg.chipIdentity <= ID_LEGACY;
         cfg.memType8Mbit <= 1'b0;
         cfg.subsysFromRom <= 1'b0;
         cfg.subsysIdPreset <= `SUBSYS_ZERO;
         cfg.subsysRomFirst <= `SUBSYS_ROM_FIRST;
         cfg.subsysRomLast <= `SUBSYS_ROM_LAST;
         cfg.bus66Capable <= 1'b0;
      end
      else
      begin
         // [RULE6] agp rate select
         cfg.agpOneX <= cfg.effCfg[`BIT_AGP];
         // [RULE7] tv timing format
         cfg.tvFormat <= tv_format_e'(cfg.effCfg[`BIT_TV_HI:`BIT_TV_LO]);
         cfg.tvEnabled <= (cfg.effCfg[`BIT_TV_HI:`BIT_TV_LO] == TV_NTSC) ||
            (cfg.effCfg[`BIT_TV_HI:`BIT_TV_LO] == TV_PAL);
         // [RULE8] reference clock rate
         cfg.refClk14m <= cfg.effCfg[`BIT_XTAL];
         cfg.hostIsAgp <= cfg.effCfg[`BIT_HOST];
         // [RULE9] framebuffer width
         cfg.fbWide128 <= cfg.effCfg[`BIT_WIDTH];
         // [RULE10] power management presence
         cfg.pmRegsPresent <= cfg.effCfg[`BIT_PM];
         // [RULE11] identity follows pm bit
         cfg.chipIdentity <= cfg.effCfg[`BIT_PM] ? ID_PM : ID_LEGACY;
         // [RULE12] memory type
         cfg.memType8Mbit <= cfg.effCfg[`BIT_RAM];
         // [RULE13] subsystem id source
         cfg.subsysFromRom <= cfg.effCfg[`BIT_SUBV];
         cfg.subsysIdPreset <= `SUBSYS_ZERO;
         // [RULE14] 66 MHz capable bit
         cfg.bus66Capable <= cfg.effCfg[`BIT_SPEED];
      end
   end

   default clocking dc @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   tv_decode_a: assert property ($past(cfg.effCfg[`BIT_TV_HI:`BIT_TV_LO]) == TV_OFF |-> // [RULE7]
      cfg.tvFormat == TV_OFF && !cfg.tvEnabled)
      else $error("tv format decode wrong");
   chip_identity_a: assert property (##1 cfg.chipIdentity == // [RULE11]
      ($past(cfg.effCfg[`BIT_PM]) ? ID_PM : ID_LEGACY) && cfg.pmRegsPresent == $past(cfg.effCfg[`BIT_PM]))
      else $error("identity does not follow pm bit");
   bus_speed_a: assert property ($changed(cfg.effCfg[`BIT_SPEED]) |=> // [RULE14]
      cfg.bus66Capable == $past(cfg.effCfg[`BIT_SPEED]))
      else $error("66 MHz bit does not follow config");
endmodule

// file: power_on_strap_config.sv
`timescale 1ns/1ps
`include "strap_cfg_map.svh"

// Notes on behaviour
// [RULE1] latch strap pins at reset release; bus idle before
// [RULE2] writable register holds config plus select bit 11
// [RULE3] host write updates writable register, not latches
// [RULE4] select 0 uses latches, 1 uses register
// [RULE5] host read returns source chosen by select
// [RULE6] bit 9: 0 agp 2X, 1 agp 1X
// [RULE7] bits 8:7 reserved, NTSC, PAL, TV off
// [RULE8] bit 6: 13.5 or 14.31818 MHz reference
// [RULE9] bit 4: 64-bit with upper half off, 128-bit
// [RULE10] bit 3: power management registers present
// [RULE11] identity field has two values by pm bit
// [RULE12] bit 2: memory type selection
// [RULE13] bit 1: subsystem ids zero or from rom
// [RULE14] bit 0: reports 33 or 66 MHz capable
// [RULE15] select bit cleared during reset
module power_on_strap_config
   import strap_cfg_pkg::*;
#(
   parameter int ADDR_W = 32,
   parameter logic [7:0] ID_LEGACY = 8'h5A,
   parameter logic [7:0] ID_PM = 8'h5B
)
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [`CFG_W-1:0] strapPins,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic busEnable,
   output logic agpOneX,
   output tv_format_e tvFormat,
   output logic tvEnabled,
   output logic refClk14m,
   output logic hostIsAgp,
   output logic fbWide128,
   output logic fbUpperOe,
   output logic pmRegsPresent,
   output logic [7:0] chipIdentity,
   output logic memType8Mbit,
   output logic subsysFromRom,
   output logic [15:0] subsysIdPreset,
   output logic [7:0] subsysRomFirst,
   output logic [7:0] subsysRomLast,
   output logic bus66Capable
);
   if (ADDR_W < 21 || ADDR_W > 32)
   begin : badAddrWidth
      $error("address width cannot reach the register");
   end

   localparam logic [ADDR_W-1:0] REG_ADDR = ADDR_W'(`CFG_ADDR);

   // word seen by software for the current source
   function automatic logic [31:0] readWord(input logic sel, input cfg_t latched,
      input cfg_t written);
      logic [31:0] word;
      word = `WORD_ZERO;
      word[`CFG_W-1:0] = sel ? written : latched;
      word[`SEL_BIT] = sel;
      return word;
   endfunction

   function automatic logic hitsReg(input logic [ADDR_W-1:0] addr);
      return addr == REG_ADDR;
   endfunction

   logic [`CFG_W-1:0] strapMeta;
   logic [`CFG_W-1:0] strapSync;
   cfg_t strapLatch;
   logic captured;
   cfg_t cfgReg;
   logic selReg;
   cfg_t effCfg;

   logic awHeld;
   logic [ADDR_W-1:0] awAddrHeld;
   logic wHeld;
   logic [31:0] wDataHeld;
   logic [3:0] wStrbHeld;
   logic awTake;
   logic wTake;
   logic arTake;
   logic wrDo;
   logic wrHit;

   strap_cfg_if cfgBus ();

   // pins settle during reset, so these stay free of reset
   always_ff @(posedge ref_clk)
   begin
      strapMeta <= strapPins;
      strapSync <= strapMeta;
   end

   // [RULE1] strap capture at release
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         captured <= 1'b0;
         strapLatch <= `CFG_RST;
      end
      else if (!captured)
      begin
         captured <= 1'b1;
         strapLatch <= strapSync;
      end
   end

   // bus stays off until the straps are held
   assign busEnable = captured;

   // [RULE1] no handshake before capture
   assign awready = captured && !awHeld && !bvalid;
   assign wready = captured && !wHeld && !bvalid;
   assign arready = captured && !rvalid;

   assign awTake = awvalid && awready;
   assign wTake = wvalid && wready;
   assign arTake = arvalid && arready;
   assign wrDo = awHeld && wHeld && !bvalid;
   assign wrHit = hitsReg(awAddrHeld);

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         awHeld <= 1'b0;
         awAddrHeld <= '0;
      end
      else if (awTake)
      begin
         awHeld <= 1'b1;
         awAddrHeld <= awaddr;
      end
      else if (wrDo)
      begin
         awHeld <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wHeld <= 1'b0;
         wDataHeld <= `WORD_ZERO;
         wStrbHeld <= 4'h0;
      end
      else if (wTake)
      begin
         wHeld <= 1'b1;
         wDataHeld <= wdata;
         wStrbHeld <= wstrb;
      end
      else if (wrDo)
      begin
         wHeld <= 1'b0;
      end
   end

   // [RULE2] writable config register with select bit
   // [RULE3] writes never touch the latches
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cfgReg <= `CFG_RST;
      end
      else if (wrDo && wrHit)
      begin
         if (wStrbHeld[0])
         begin
            cfgReg[`LANE0_HI:0] <= wDataHeld[`LANE0_HI:0];
         end
         if (wStrbHeld[1])
         begin
            cfgReg[`CFG_W-1:`LANE1_LO] <= wDataHeld[`CFG_W-1:`LANE1_LO];
         end
      end
   end

   // [RULE15] select cleared by reset
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         selReg <= `SEL_RST;
      end
      else if (wrDo && wrHit && wStrbHeld[1])
      begin
         selReg <= wDataHeld[`SEL_BIT];
      end
   end

   // unmapped writes are dropped with an error answer
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         bvalid <= 1'b0;
         bresp <= `RESP_OKAY;
      end
      else if (wrDo)
      begin
         bvalid <= 1'b1;
         bresp <= wrHit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (bready)
      begin
         bvalid <= 1'b0;
      end
   end

   // [RULE5] read follows current select
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rvalid <= 1'b0;
         rdata <= `WORD_ZERO;
         rresp <= `RESP_OKAY;
      end
      else if (arTake)
      begin
         rvalid <= 1'b1;
         if (hitsReg(araddr))
         begin
            rdata <= readWord(selReg, strapLatch, cfgReg);
            rresp <= `RESP_OKAY;
         end
         else
         begin
            rdata <= `WORD_ZERO;
            rresp <= `RESP_SLVERR;
         end
      end
      else if (rready)
      begin
         rvalid <= 1'b0;
      end
   end

   // [RULE4] source select for the live config
   assign effCfg = selReg ? cfgReg : strapLatch;
   assign cfgBus.effCfg = effCfg;

   strap_field_decode #(
      .ID_LEGACY(ID_LEGACY),
      .ID_PM(ID_PM)
   ) fieldDecode (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .cfg(cfgBus)
   );

   assign agpOneX = cfgBus.agpOneX;
   assign tvFormat = cfgBus.tvFormat;
   assign tvEnabled = cfgBus.tvEnabled;
   assign refClk14m = cfgBus.refClk14m;
   assign hostIsAgp = cfgBus.hostIsAgp;
   assign fbWide128 = cfgBus.fbWide128;
   // [RULE9] upper data half off in 64-bit mode
   assign fbUpperOe = cfgBus.fbWide128;
   assign pmRegsPresent = cfgBus.pmRegsPresent;
   assign chipIdentity = cfgBus.chipIdentity;
   assign memType8Mbit = cfgBus.memType8Mbit;
   assign subsysFromRom = cfgBus.subsysFromRom;
   assign subsysIdPreset = cfgBus.subsysIdPreset;
   assign subsysRomFirst = cfgBus.subsysRomFirst;
   assign subsysRomLast = cfgBus.subsysRomLast;
   assign bus66Capable = cfgBus.bus66Capable;

   default clocking mc @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   sequence hitWrite;
      wrDo && wrHit && wStrbHeld[0] && wStrbHeld[1];
   endsequence

   sequence regUpdated;
      ##1 cfgReg == $past(wDataHeld[`CFG_W-1:0]) && selReg == $past(wDataHeld[`SEL_BIT]);
   endsequence

   bus_held_off_a: assert property (!captured |-> // [RULE1]
      !awready && !wready && !arready && !busEnable)
      else $error("bus answered before strap capture");

   latch_stable_a: assert property (captured |=> $stable(strapLatch)) // [RULE1]
      else $error("strap latch changed after capture");

   reg_write_a: assert property (hitWrite |-> regUpdated) // [RULE2]
      else $error("writable register not updated");

   latch_untouched_a: assert property (wrDo |=> $stable(strapLatch)) // [RULE3]
      else $error("write altered strap latch");

   source_select_a: assert property (##1 agpOneX == // [RULE4]
      ($past(selReg) ? $past(cfgReg[`BIT_AGP]) : $past(strapLatch[`BIT_AGP])))
      else $error("live config from wrong source");

   read_source_a: assert property (arTake && hitsReg(araddr) |=> // [RULE5]
      rvalid && rdata == readWord($past(selReg), $past(strapLatch), $past(cfgReg)))
      else $error("read returned wrong source");

   select_reset_a: assert property (!captured |-> !selReg && effCfg == strapLatch) // [RULE15]
      else $error("select not clear after reset");

   upper_half_a: assert property (##1 fbUpperOe == $past(effCfg[`BIT_WIDTH])) // [RULE9]
      else $error("upper data half enable wrong");

   subsys_src_a: assert property (##1 subsysFromRom == $past(effCfg[`BIT_SUBV]) && // [RULE13]
      subsysIdPreset == `SUBSYS_ZERO)
      else $error("subsystem id source wrong");

   write_answer_a: assert property (wrDo |=> bvalid && // [RULE3]
      bresp == ($past(wrHit) ? `RESP_OKAY : `RESP_SLVERR))
      else $error("write response missing");
endmodule

// file: strap_board_model.sv
`timescale 1ns/1ps

module strap_board_model
(
   input wire logic [9:0] pullPattern,
   output logic [9:0] strapPins
);
   // every pin is strapped by a resistor, so none floats
   assign strapPins = pullPattern;
endmodule

// file: tb_top.sv
`timescale 1ns/1ps
`include "strap_cfg_map.svh"

module tb_top
   import strap_cfg_pkg::*;
;
   localparam logic [7:0] ID_A = 8'h5A;
   localparam logic [7:0] ID_B = 8'h5B;
   localparam logic [9:0] STRAP_A = 10'h0C9;
   localparam logic [9:0] STRAP_B = 10'h314;
   localparam int LIMIT = 3000;
   typedef struct
   {
      logic [9:0] cfg;
      logic [7:0] id;
      logic tvOn;
   } row_s;
   row_s rows [6] = '{'{10'h000, ID_A, 1'b0}, '{10'h3FF, ID_B, 1'b0},
      '{10'h080, ID_A, 1'b1}, '{10'h108, ID_B, 1'b1}, '{10'h255, ID_A, 1'b0},
      '{10'h1AA, ID_B, 1'b0}};
   logic ref_clk, reset_n, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, busEnable, agpOneX, tvEnabled, refClk14m;
   logic hostIsAgp, fbWide128, fbUpperOe, pmRegsPresent, memType8Mbit, subsysFromRom;
   logic bus66Capable;
   logic [9:0] pullPattern, strapPins;
   logic [31:0] awaddr, wdata, araddr, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, resp;
   tv_format_e tvFormat;
   logic [7:0] chipIdentity, subsysRomFirst, subsysRomLast;
   logic [15:0] subsysIdPreset;
   int numErrors, checked, cycles;

   strap_board_model i_strap_board_model (.pullPattern(pullPattern), .strapPins(strapPins));

   power_on_strap_config #(.ADDR_W(32), .ID_LEGACY(ID_A), .ID_PM(ID_B))
   i_power_on_strap_config
   (
      .ref_clk(ref_clk), .reset_n(reset_n), .strapPins(strapPins), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .busEnable(busEnable), .agpOneX(agpOneX), .tvFormat(tvFormat),
      .tvEnabled(tvEnabled), .refClk14m(refClk14m), .hostIsAgp(hostIsAgp),
      .fbWide128(fbWide128), .fbUpperOe(fbUpperOe), .pmRegsPresent(pmRegsPresent),
      .chipIdentity(chipIdentity), .memType8Mbit(memType8Mbit),
      .subsysFromRom(subsysFromRom), .subsysIdPreset(subsysIdPreset),
      .subsysRomFirst(subsysRomFirst), .subsysRomLast(subsysRomLast),
      .bus66Capable(bus66Capable)
   );

   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, numErrors);
      if (numErrors == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         numErrors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // each channel held until taken at a rising edge; answer taken at a later edge, once bvalid is seen
   task automatic axiWrite(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
      logic bTaken;
      bTaken = 1'b0;
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!bTaken)
      begin
         @(posedge ref_clk);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
         if (bvalid && bready)
         begin
            bTaken = 1'b1;
            resp = bresp;
         end
      end
      bready <= 1'b0;
   endtask

   task automatic expectRead(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
      logic rTaken;
      logic [31:0] got;
      rTaken = 1'b0;
      got = `WORD_ZERO;
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!rTaken)
      begin
         @(posedge ref_clk);
         if (arvalid && arready)
            arvalid <= 1'b0;
         if (rvalid && rready)
         begin
            rTaken = 1'b1;
            got = rdata;
            resp = rresp;
         end
      end
      rready <= 1'b0;
      check("rdata", got, d);
      check("rresp", resp, r);
   endtask

   task automatic checkDecode(input logic [9:0] c, input logic [7:0] id, input logic tvOn);
      @(negedge ref_clk);
      check("agpOneX", agpOneX, c[9]);
      check("tvFormat", tvFormat, c[8:7]);
      check("tvEnabled", tvEnabled, tvOn);
      check("refClk14m", refClk14m, c[6]);
      check("hostIsAgp", hostIsAgp, c[5]);
      check("fbWidth", {fbUpperOe, fbWide128}, {2{c[4]}});
      check("pmRegs", pmRegsPresent, c[3]);
      check("chipId", chipIdentity, id);
      check("memType", memType8Mbit, c[2]);
      check("subsysSrc", {subsysFromRom, subsysIdPreset}, {c[1], 16'h0000});
      check("subsysRom", {subsysRomFirst, subsysRomLast}, 16'h5457);
      check("bus66", bus66Capable, c[0]);
   endtask

   task automatic doReset();
      @(posedge ref_clk);
      reset_n <= 1'b0;
      repeat (8) @(posedge ref_clk);
      @(negedge ref_clk);
      check("busEnableLow", busEnable, 1'b0);
      check("readiesLow", {awready, wready, arready}, 3'b000);
      @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      check("busEnableHigh", busEnable, 1'b1);
   endtask

   initial
   begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         numErrors++;
         summarize();
      end
   end

   initial
   begin
      reset_n = 1'b0;
      pullPattern = STRAP_A;
      {awaddr, wdata, araddr} = '0;
      {awvalid, wvalid, bready, arvalid, rready, wstrb} = '0;
      doReset();
      expectRead(`CFG_ADDR, {22'h00_0000, STRAP_A}, `RESP_OKAY);
      checkDecode(STRAP_A, ID_B, 1'b1);
      $display("test strap_capture done");
      foreach (rows[i])
      begin
         axiWrite(`CFG_ADDR, {20'h0_0000, 2'b10, rows[i].cfg}, 4'hF);
         check("bresp", resp, `RESP_OKAY);
         expectRead(`CFG_ADDR, {20'h0_0000, 2'b10, rows[i].cfg}, `RESP_OKAY);
         checkDecode(rows[i].cfg, rows[i].id, rows[i].tvOn);
      end
      $display("test override_rows done");
      axiWrite(`CFG_ADDR, 32'h0000_03FF, 4'hF);
      expectRead(`CFG_ADDR, {22'h00_0000, STRAP_A}, `RESP_OKAY);
      checkDecode(STRAP_A, ID_B, 1'b1);
      axiWrite(`CFG_ADDR, 32'h0000_0800, 4'h2);
      expectRead(`CFG_ADDR, 32'h0000_08FF, `RESP_OKAY);
      checkDecode(10'h0FF, ID_B, 1'b1);
      axiWrite(`CFG_ADDR, 32'h0000_0011, 4'h1);
      expectRead(`CFG_ADDR, 32'h0000_0811, `RESP_OKAY);
      $display("test strobes done");
      axiWrite(`CFG_ADDR + 32'h0000_0004, 32'h0000_0000, 4'hF);
      check("brespBad", resp, `RESP_SLVERR);
      expectRead(`CFG_ADDR + 32'h0000_0004, `WORD_ZERO, `RESP_SLVERR);
      expectRead(`CFG_ADDR, 32'h0000_0811, `RESP_OKAY);
      $display("test unmapped done");
      @(posedge ref_clk);
      pullPattern <= STRAP_B;
      doReset();
      expectRead(`CFG_ADDR, {22'h00_0000, STRAP_B}, `RESP_OKAY);
      checkDecode(STRAP_B, ID_A, 1'b1);
      $display("test second_reset done");
      summarize();
   end
endmodule
